// ===== design/asrc_port_ctrl.v
// Operation
// - Two stereo sections, independent settings each
// - Ratio 16:1 to 1:16, rates to 212kHz
// - Word lengths 24, 20, 18, 16 bits
// - Slave port: word and bit clock inputs
// - Master port clocks derived from section reference
// - Never both ports master at once
// - Codes 000 and 100: both ports slave
// - 001/010/011: output master, 128/512/256 fs
// - 101/110/111: input master, 128/512/256 fs
// - Role from pins or control register field
// - Role field resets to both slave
// - Slave-only reference free, at most 50MHz
// - Rate estimator compares word clocks and reference
// - Direct downsampling only when output rate higher
// - One reset reinitialises both sections
// - Writes ignored for 500ms after reset
// - Reset low holds hard power-down
// - Run bit 0 puts section in power-down
// - Registers stay accessible during soft power-down
// - Run bits reset to 0 in both banks
// - Attenuation 0.5dB steps, ramped soft mute
// - Bypass routes input data to output port
// - Software mode ignores hardware config pins except the bypass pins
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "asrc_defines.vh"

module asrc_port_ctrl #(
  parameter [24:0] INIT_CYCLES = `ASRC_INIT_MS * `ASRC_CLK_KHZ
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Control mode select
  input wire control_mode_sel,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Reference clocks
  input wire ref_clock_sect_a,
  input wire ref_clock_sect_b,
  // Hardware configuration pins, bit 0 is section A
  input wire [2:0] port_role_pin_a,
  input wire [2:0] port_role_pin_b,
  input wire [1:0] bypass_pin,
  input wire [1:0] mute_pin,
  input wire [1:0] direct_down_pin,
  // Input port clocks
  input wire [1:0] input_word_clock_in,
  output wire [1:0] input_word_clock_out,
  output wire [1:0] input_word_clock_oe,
  input wire [1:0] input_bit_clock_in,
  output wire [1:0] input_bit_clock_out,
  output wire [1:0] input_bit_clock_oe,
  // Output port clocks
  input wire [1:0] output_word_clock_in,
  output wire [1:0] output_word_clock_out,
  output wire [1:0] output_word_clock_oe,
  input wire [1:0] output_bit_clock_in,
  output wire [1:0] output_bit_clock_out,
  output wire [1:0] output_bit_clock_oe,
  // Serial audio data
  input wire [1:0] sdata_in,
  output wire [1:0] sdata_out,
  // Conversion core side
  input wire [1:0] conv_sdata,
  output wire [1:0] sect_run,
  output wire [1:0] sect_ready,
  output wire [1:0] bypass_active,
  output wire [1:0] direct_down_sel,
  output wire [3:0] word_length_code,
  output wire [15:0] gain_level,
  output wire [31:0] in_period,
  output wire [31:0] out_period
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Reference edges per half bit clock
  function [2:0] half_count;
    input [1:0] rate;
    begin
      case (rate)
        2'h1: half_count = 3'h1;
        2'h3: half_count = 3'h2;
        2'h2: half_count = 3'h4;
        default: half_count = 3'h1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Mode select synchroniser
  // ----------------------------------------
  reg mode_s1;
  reg mode_s2;
  wire hw_mode;

  always @(posedge mclk) begin
    if (!reset_n) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= control_mode_sel;
      mode_s2 <= mode_s1;
    end
  end

  assign hw_mode = mode_s2;

  // ----------------------------------------
  // Register bank and bus slave
  // ----------------------------------------
  reg [23:0] ctrl_reg [0:1];
  reg [24:0] init_cnt;
  reg [31:0] rd_word;
  wire init_busy;
  wire [15:0] stat_a;
  wire [15:0] stat_b;

  assign init_busy = (init_cnt != 25'h0);

  always @* begin
    case (avs_address)
      `ASRC_REG_CTRL_A: rd_word = {8'h00, ctrl_reg[0]};
      `ASRC_REG_CTRL_B: rd_word = {8'h00, ctrl_reg[1]};
      `ASRC_REG_STAT_A: rd_word = {16'h0000, stat_a};
      `ASRC_REG_STAT_B: rd_word = {16'h0000, stat_b};
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl_reg[0] <= `ASRC_CTRL_RST;
      ctrl_reg[1] <= `ASRC_CTRL_RST;
      init_cnt <= INIT_CYCLES;
    end else begin
      if (init_busy) begin
        init_cnt <= init_cnt - 25'h1;
      end
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
        if (avs_write && !init_busy) begin
          case (avs_address)
            `ASRC_REG_CTRL_A: ctrl_reg[0] <= avs_writedata[23:0];
            `ASRC_REG_CTRL_B: ctrl_reg[1] <= avs_writedata[23:0];
            default: ctrl_reg[0] <= ctrl_reg[0];
          endcase
        end
      end else if (avs_read || avs_write) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_word : 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Per-section pin buses
  // ----------------------------------------
  wire [11:0] pin_bus [0:1];

  assign pin_bus[0] = {ref_clock_sect_a, input_word_clock_in[0], input_bit_clock_in[0],
                       output_word_clock_in[0], output_bit_clock_in[0], sdata_in[0],
                       port_role_pin_a, bypass_pin[0], mute_pin[0], direct_down_pin[0]};
  assign pin_bus[1] = {ref_clock_sect_b, input_word_clock_in[1], input_bit_clock_in[1],
                       output_word_clock_in[1], output_bit_clock_in[1], sdata_in[1],
                       port_role_pin_b, bypass_pin[1], mute_pin[1], direct_down_pin[1]};

  // ----------------------------------------
  // Sections
  // ----------------------------------------
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : sect
      reg [11:0] sy1;
      reg [11:0] sy2;
      reg ref_d;
      reg [2:0] hcnt;
      reg [4:0] bcnt;
      reg mbit;
      reg mword;
      reg iw_d;
      reg ow_d;
      reg [15:0] icnt;
      reg [15:0] ocnt;
      reg [15:0] iper;
      reg [15:0] oper;
      reg [7:0] gain;
      reg iwo, ibo, iwoe, iboe, owo, obo, owoe, oboe;
      reg sdo, run_q, rdy_q, byp_q, dds_q, fast_q, rok_q;
      reg [1:0] owl_q;
      wire ref_rise;
      wire [2:0] role;
      wire run, byp, mute, ddn, om, im;
      wire [1:0] owl;
      wire [7:0] att;
      wire [7:0] target;
      wire iw, ow, iw_rise, ow_rise;
      wire fast, rok;

      always @(posedge mclk) begin
        if (!reset_n) begin
          sy1 <= 12'h000;
          sy2 <= 12'h000;
        end else begin
          sy1 <= pin_bus[s];
          sy2 <= sy1;
        end
      end

      // Effective settings
      assign role = hw_mode ? sy2[5:3] : ctrl_reg[s][`ASRC_F_ROLE_LO+2:`ASRC_F_ROLE_LO];
      assign run = hw_mode ? 1'b1 : ctrl_reg[s][`ASRC_F_RUN_N];
      assign byp = sy2[2] | (!hw_mode & ctrl_reg[s][`ASRC_F_BYPASS]);
      assign mute = hw_mode ? sy2[1] : ctrl_reg[s][`ASRC_F_MUTE];
      assign ddn = hw_mode ? sy2[0] : ctrl_reg[s][`ASRC_F_DDN];
      assign owl = hw_mode ? `ASRC_OWL_24 : ctrl_reg[s][`ASRC_F_OWL_LO+1:`ASRC_F_OWL_LO];
      assign att = hw_mode ? 8'h00 : ctrl_reg[s][`ASRC_F_ATT_LO+7:`ASRC_F_ATT_LO];
      assign om = !role[2] && (role[1:0] != 2'h0);
      assign im = role[2] && (role[1:0] != 2'h0);
      assign ref_rise = sy2[11] & !ref_d;

      // Master clock divider from the section reference
      always @(posedge mclk) begin
        if (!reset_n || !run || !(om || im)) begin
          hcnt <= 3'h0;
          bcnt <= 5'h00;
          mbit <= 1'b0;
          mword <= 1'b0;
        end else begin
          if (ref_rise) begin
            if (hcnt == half_count(role[1:0]) - 3'h1) begin
              hcnt <= 3'h0;
              mbit <= !mbit;
              if (mbit) begin
                bcnt <= bcnt + 5'h01;
                if (bcnt == `ASRC_BITS_PER_HALF) begin
                  mword <= !mword;
                end
              end
            end else begin
              hcnt <= hcnt + 3'h1;
            end
          end
        end
      end

      // Port pin drive
      always @(posedge mclk) begin
        if (!reset_n) begin
          iwo <= 1'b0;
          ibo <= 1'b0;
          iwoe <= 1'b0;
          iboe <= 1'b0;
          owo <= 1'b0;
          obo <= 1'b0;
          owoe <= 1'b0;
          oboe <= 1'b0;
        end else begin
          iwoe <= im;
          iboe <= im;
          owoe <= om;
          oboe <= om;
          iwo <= im & mword;
          ibo <= im & mbit;
          owo <= om & mword;
          obo <= om & mbit;
        end
      end

      // Rate estimator in reference periods
      assign iw = im ? mword : sy2[10];
      assign ow = om ? mword : sy2[8];
      assign iw_rise = iw & !iw_d;
      assign ow_rise = ow & !ow_d;
      assign fast = (oper != 16'h0000) && (oper < iper);
      assign rok = (iper != 16'h0000) && (oper != 16'h0000) &&
                   ({4'h0, iper} <= {oper, 4'h0}) && ({4'h0, oper} <= {iper, 4'h0});

      always @(posedge mclk) begin
        if (!reset_n) begin
          ref_d <= 1'b0;
          iw_d <= 1'b0;
          ow_d <= 1'b0;
          icnt <= 16'h0000;
          ocnt <= 16'h0000;
          iper <= 16'h0000;
          oper <= 16'h0000;
        end else begin
          ref_d <= sy2[11];
          iw_d <= iw;
          ow_d <= ow;
          if (iw_rise) begin
            iper <= icnt;
            icnt <= 16'h0000;
          end else if (ref_rise && icnt != `ASRC_PERIOD_MAX) begin
            icnt <= icnt + 16'h0001;
          end
          if (ow_rise) begin
            oper <= ocnt;
            ocnt <= 16'h0000;
          end else if (ref_rise && ocnt != `ASRC_PERIOD_MAX) begin
            ocnt <= ocnt + 16'h0001;
          end
        end
      end

      // Gain ramp, one 0.5dB step per output frame
      assign target = mute ? `ASRC_MUTE_LEVEL : att;

      always @(posedge mclk) begin
        if (!reset_n) begin
          gain <= `ASRC_GAIN_RST;
        end else if (ow_rise) begin
          if (gain < target) begin
            gain <= gain + 8'h01;
          end else if (gain > target) begin
            gain <= gain - 8'h01;
          end
        end
      end

      // Status, data path and core controls
      always @(posedge mclk) begin
        if (!reset_n) begin
          sdo <= 1'b0;
          run_q <= 1'b0;
          rdy_q <= 1'b0;
          byp_q <= 1'b0;
          dds_q <= 1'b0;
          fast_q <= 1'b0;
          rok_q <= 1'b0;
          owl_q <= `ASRC_OWL_24;
        end else begin
          sdo <= run & (byp ? sy2[6] : conv_sdata[s]);
          run_q <= run;
          rdy_q <= run & rok;
          byp_q <= byp;
          dds_q <= ddn & fast;
          fast_q <= fast;
          rok_q <= rok;
          owl_q <= owl;
        end
      end

      assign input_word_clock_out[s] = iwo;
      assign input_bit_clock_out[s] = ibo;
      assign input_word_clock_oe[s] = iwoe;
      assign input_bit_clock_oe[s] = iboe;
      assign output_word_clock_out[s] = owo;
      assign output_bit_clock_out[s] = obo;
      assign output_word_clock_oe[s] = owoe;
      assign output_bit_clock_oe[s] = oboe;
      assign sdata_out[s] = sdo;
      assign sect_run[s] = run_q;
      assign sect_ready[s] = rdy_q;
      assign bypass_active[s] = byp_q;
      assign direct_down_sel[s] = dds_q;
      assign word_length_code[2*s+1:2*s] = owl_q;
      assign gain_level[8*s+7:8*s] = gain;
      assign in_period[16*s+15:16*s] = iper;
      assign out_period[16*s+15:16*s] = oper;
    end
  endgenerate

  // ----------------------------------------
  // Status words
  // ----------------------------------------
  assign stat_a = {sect[0].gain, hw_mode, sect[0].run_q, sect[0].byp_q, sect[0].dds_q,
                   sect[0].rok_q, sect[0].fast_q, sect[0].rdy_q, init_busy};
  assign stat_b = {sect[1].gain, hw_mode, sect[1].run_q, sect[1].byp_q, sect[1].dds_q,
                   sect[1].rok_q, sect[1].fast_q, sect[1].rdy_q, init_busy};

endmodule

// ===== shared/asrc_defines.vh
`ifndef ASRC_DEFINES_VH
`define ASRC_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASRC_CLK_KHZ 40000
`define ASRC_INIT_MS 500
`define ASRC_RST_MIN_NS 500

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ASRC_REG_CTRL_A 4'h0
`define ASRC_REG_STAT_A 4'h4
`define ASRC_REG_CTRL_B 4'h8
`define ASRC_REG_STAT_B 4'hc

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define ASRC_CTRL_RST 24'h000000
`define ASRC_F_ROLE_LO 0
`define ASRC_F_BYPASS 3
`define ASRC_F_RUN_N 4
`define ASRC_F_MUTE 5
`define ASRC_F_DDN 6
`define ASRC_F_OWL_LO 8
`define ASRC_F_ATT_LO 16

// ----------------------------------------
// Codes and limits
// ----------------------------------------
`define ASRC_ROLE_SLAVE 3'h0
`define ASRC_OWL_24 2'h0
`define ASRC_MUTE_LEVEL 8'hff
`define ASRC_GAIN_RST 8'hff
`define ASRC_BITS_PER_HALF 5'h1f
`define ASRC_PERIOD_MAX 16'hffff

`endif

// ===== test/asrc_port_sva.sv
`timescale 1ns/1ps
module asrc_port_sva (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Port clocks
  input wire [1:0] input_word_clock_oe,
  input wire [1:0] input_bit_clock_oe,
  input wire [1:0] output_word_clock_oe,
  input wire [1:0] output_bit_clock_oe,
  input wire [1:0] output_bit_clock_out,
  // Section state
  input wire [1:0] sdata_out,
  input wire [1:0] sect_run,
  input wire [1:0] sect_ready,
  input wire [15:0] gain_level
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire req = avs_read || avs_write;
  bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer late or long");
  bus_idle_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  one_master_a: assert property ((input_word_clock_oe & output_word_clock_oe) == 2'h0)
    else $error("two master ports");
  clock_pair_a: assert property (input_word_clock_oe == input_bit_clock_oe && output_word_clock_oe == output_bit_clock_oe)
    else $error("word and bit clock roles differ");
  slave_quiet_a: assert property (output_bit_clock_oe == 2'h0 && $past(output_bit_clock_oe) == 2'h0 |-> output_bit_clock_out == 2'h0)
    else $error("slave port clock driven");
  pdn_quiet_a: assert property ((sect_run == 2'h0) [*3] |-> sdata_out == 2'h0 && output_bit_clock_out == 2'h0)
    else $error("powered down section active");
  ready_run_a: assert property ((sect_ready & ~sect_run) == 2'h0)
    else $error("ready while not running");
  gain_step_a: assert property (gain_level[7:0] != $past(gain_level[7:0]) |-> gain_level[7:0] - $past(gain_level[7:0]) == 8'h01 || $past(gain_level[7:0]) - gain_level[7:0] == 8'h01)
    else $error("gain jumped");
  hard_pdn_a: assert property (disable iff (1'b0) !reset_n |=> avs_waitrequest && sdata_out == 2'h0 && sect_run == 2'h0)
    else $error("active during reset");
  cover property (avs_write && !avs_waitrequest);
  cover property (output_bit_clock_oe[0] && sect_run[0]);
  cover property (sect_ready[0]);
endmodule
bind asrc_port_ctrl asrc_port_sva chk (.mclk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .input_word_clock_oe,
  .input_bit_clock_oe, .output_word_clock_oe, .output_bit_clock_oe, .output_bit_clock_out, .sdata_out, .sect_run,
  .sect_ready, .gain_level);

// ===== test/asrc_far_end.sv
`timescale 1ns/1ps
module asrc_far_end (
  // Clock
  input wire mclk,
  // Far-side lines
  output wire ref_clock,
  output wire word_in,
  output wire word_out,
  output wire bit_clk
);
  // ----------------------------------------
  // Audio devices and reference source
  // ----------------------------------------
  reg [8:0] cnt = 9'h000;
  always @(posedge mclk) begin
    cnt <= cnt + 9'h001;
  end
  assign ref_clock = cnt[2];
  assign bit_clk = cnt[1];
  assign word_in = cnt[8];
  assign word_out = cnt[7];
endmodule

// ===== test/asrc_port_mode_reset_control_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module asrc_port_mode_reset_control_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  reg mclk = 1'b0, reset_n = 1'b0, control_mode_sel = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0, q;
  reg [2:0] port_role_pin_a = 3'h0, port_role_pin_b = 3'h0;
  reg [1:0] sdata_in = 2'h0, conv_sdata = 2'h0, bypass_pin = 2'h0, mute_pin = 2'h0, direct_down_pin = 2'h0;
  integer errors = 0, samples_checked = 0;
  wire [31:0] avs_readdata, in_period, out_period;
  wire avs_waitrequest, rck, fwi, fwo, fbk;
  wire [1:0] input_word_clock_in, input_word_clock_out, input_word_clock_oe, input_bit_clock_in, input_bit_clock_out;
  wire [1:0] input_bit_clock_oe, output_word_clock_in, output_word_clock_out, output_word_clock_oe, output_bit_clock_in;
  wire [1:0] output_bit_clock_out, output_bit_clock_oe, sdata_out, sect_run, sect_ready, bypass_active, direct_down_sel;
  wire [3:0] word_length_code;
  wire [15:0] gain_level;
  assign input_word_clock_in = (input_word_clock_oe & input_word_clock_out) | (~input_word_clock_oe & {2{fwi}});
  assign input_bit_clock_in = (input_bit_clock_oe & input_bit_clock_out) | (~input_bit_clock_oe & {2{fbk}});
  assign output_word_clock_in = (output_word_clock_oe & output_word_clock_out) | (~output_word_clock_oe & {2{fwo}});
  assign output_bit_clock_in = (output_bit_clock_oe & output_bit_clock_out) | (~output_bit_clock_oe & {2{fbk}});
  asrc_far_end far (.mclk, .ref_clock(rck), .word_in(fwi), .word_out(fwo), .bit_clk(fbk));
  asrc_port_ctrl #(.INIT_CYCLES(25'h0000010)) dut (.mclk, .reset_n, .control_mode_sel, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .ref_clock_sect_a(rck), .ref_clock_sect_b(rck),
    .port_role_pin_a, .port_role_pin_b, .bypass_pin, .mute_pin, .direct_down_pin,
    .input_word_clock_in, .input_word_clock_out, .input_word_clock_oe, .input_bit_clock_in, .input_bit_clock_out,
    .input_bit_clock_oe, .output_word_clock_in, .output_word_clock_out, .output_word_clock_oe, .output_bit_clock_in,
    .output_bit_clock_out, .output_bit_clock_oe, .sdata_in, .sdata_out, .conv_sdata, .sect_run, .sect_ready,
    .bypass_active, .direct_down_sel, .word_length_code, .gain_level, .in_period, .out_period);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task bus(input reg w, input reg [3:0] a, input reg [31:0] d);
    integer n;
    begin
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        @(posedge mclk);
        n++;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
      if (n >= 50) begin
        errors++;
        summarize;
      end
    end
  endtask
  task do_reset;
    begin
      reset_n <= 1'b0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      bus(0, 4'h0, 32'h0);
      `CHK("ctrl a", 32'h0, q)
      bus(0, 4'h8, 32'h0);
      `CHK("ctrl b", 32'h0, q)
      bus(0, 4'h4, 32'h0);
      `CHK("busy", 1'b1, q[0])
      bus(1, 4'h0, 32'h13);
      repeat (20) @(posedge mclk);
      bus(0, 4'h0, 32'h0);
      `CHK("early write", 32'h0, q)
    end
  endtask
  task t_roles;
    integer c;
    begin
      for (c = 0; c < 8; c++) begin
        bus(1, 4'h0, c[31:0]);
        repeat (4) @(posedge mclk);
        `CHK("out master", c[1:0] != 2'h0 && !c[2], output_word_clock_oe[0])
        `CHK("in master", c[1:0] != 2'h0 && c[2], input_word_clock_oe[0])
        `CHK("b roles", 2'h0, {input_word_clock_oe[1], output_word_clock_oe[1]})
      end
    end
  endtask
  task t_clock;
    integer i, n, e;
    reg [2:0] c;
    reg p, b;
    begin
      for (i = 0; i < 4; i++) begin
        c = 12'h29d >> (3 * i);
        bus(1, 4'h0, {27'h0, 2'h2, c});
        repeat (16) @(posedge mclk);
        n = 0;
        p = 1'b0;
        repeat (256) begin
          @(posedge mclk);
          b = c[2] ? input_bit_clock_out[0] : output_bit_clock_out[0];
          if (b === 1'b1 && p === 1'b0) n++;
          p = b;
        end
        e = (c[1:0] == 2'h1) ? 16 : (c[1:0] == 2'h3) ? 8 : 4;
        `CHK("bit rate", 1'b1, n >= e - 1 && n <= e + 1)
      end
      bus(1, 4'h0, 32'h1);
      repeat (8) @(posedge mclk);
      `CHK("pdn clock", 2'h0, output_bit_clock_out)
      bus(0, 4'h0, 32'h0);
      `CHK("pdn access", 32'h1, q)
    end
  endtask
  task t_rate;
    reg [7:0] g;
    begin
      bus(1, 4'h0, 32'h350);
      repeat (1500) @(posedge mclk);
      bus(0, 4'h4, 32'h0);
      `CHK("rate stat", 6'h2f, q[6:1])
      `CHK("in period", 16'h0040, in_period[15:0])
      `CHK("out period", 16'h0020, out_period[15:0])
      `CHK("gain ramp", 1'b1, gain_level[7:0] < 8'hff)
      `CHK("word length", 4'h3, word_length_code)
      `CHK("direct down", 2'h1, direct_down_sel)
      g = gain_level[7:0];
      bus(1, 4'h0, 32'h370);
      repeat (600) @(posedge mclk);
      `CHK("mute ramp", 1'b1, gain_level[7:0] > g)
    end
  endtask
  task t_bypass;
    begin
      bus(1, 4'h0, 32'h18);
      sdata_in <= 2'h1;
      conv_sdata <= 2'h2;
      repeat (6) @(posedge mclk);
      `CHK("bypass 1", 2'h1, sdata_out)
      `CHK("bypass flag", 2'h1, bypass_active)
      sdata_in <= 2'h0;
      conv_sdata <= 2'h1;
      repeat (6) @(posedge mclk);
      `CHK("bypass 0", 2'h0, sdata_out)
      bus(1, 4'h0, 32'h10);
      repeat (6) @(posedge mclk);
      `CHK("core data", 2'h1, sdata_out)
      `CHK("bypass off", 2'h0, bypass_active)
    end
  endtask
  task t_hw;
    reg [7:0] g;
    begin
      bus(1, 4'h0, 32'h0);
      g = gain_level[7:0];
      port_role_pin_a <= 3'h5;
      port_role_pin_b <= 3'h1;
      bypass_pin <= 2'h2;
      mute_pin <= 2'h1;
      direct_down_pin <= 2'h3;
      control_mode_sel <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK("hw roles", 4'h6, {input_word_clock_oe, output_word_clock_oe})
      `CHK("hw run", 2'h3, sect_run)
      `CHK("hw bypass", 2'h2, bypass_active)
      `CHK("hw direct down", 2'h3, direct_down_sel)
      repeat (600) @(posedge mclk);
      `CHK("hw mute ramp", 1'b1, gain_level[7:0] > g)
      control_mode_sel <= 1'b0;
      repeat (8) @(posedge mclk);
      `CHK("sw roles", 4'h0, {input_word_clock_oe, output_word_clock_oe})
      `CHK("sw bypass pin", 2'h2, bypass_active)
      `CHK("sw direct down", 2'h0, direct_down_sel)
      bypass_pin <= 2'h0;
      mute_pin <= 2'h0;
      direct_down_pin <= 2'h0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    @(posedge mclk);
    do_reset;
    t_roles;
    t_clock;
    t_rate;
    t_bypass;
    t_hw;
    do_reset;
    summarize;
  end
endmodule
